/* File: hw/acyclic_parameter_access.sv */
// Parameter and instruction bank served by decoded acyclic records.
// Assumes frames are unpacked upstream into one request per valid pulse,
// and that raw readings come from logic on the same clock.
module acyclic_parameter_access #(
   parameter logic [15:0] DEVICE_TYPE = 16'h0A5A, // Arbitrary value
   parameter logic [15:0] FW_VERSION = 16'h0064, // Arbitrary value
   parameter logic [15:0] PARAM_SLOT = 16'h0001,
   parameter int unsigned RECONNECT_CYCLES =
      param_bank_pkg::RECONNECT_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Device status
   input wire logic i_boot_done,
   input wire logic i_link_ok,
   input wire logic i_overload,
   input wire logic signed [15:0] i_raw_reading,
   // Request
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic [15:0] i_req_slot,
   input wire logic [7:0] i_req_index,
   input wire logic [31:0] i_req_wdata,
   // Answer
   output logic o_busy,
   output logic o_rsp_valid,
   output logic [2:0] o_rsp_status,
   output logic [31:0] o_rsp_rdata,
   // Connection
   output logic o_connected,
   // Parameter values
   output logic o_network_filter_enable,
   output logic o_analog_filter_enable,
   output logic [15:0] o_zero_offset,
   output logic [15:0] o_scale_gain,
   output logic [31:0] o_full_scale_force,
   output logic [31:0] o_analog_output_scaling,
   output logic [15:0] o_network_filter_cutoff,
   output logic [15:0] o_analog_filter_cutoff
);
   typedef struct packed {
      logic link_s1;
      logic link_s2;
      logic ovl_s1;
      logic ovl_s2;
      param_bank_pkg::conn_e conn;
      logic connected;
      logic [31:0] wait_cnt;
      param_bank_pkg::phase_e phase;
      logic busy;
      logic rsp_valid;
      logic [2:0] rsp_status;
      logic [31:0] rsp_rdata;
      logic net_flt_en;
      logic ana_flt_en;
      logic [15:0] offset;
      logic [15:0] gain;
      logic [31:0] force_fs;
      logic [31:0] scaling;
      logic [15:0] net_cut;
      logic [15:0] ana_cut;
   } bank_s;

   bank_s st_r;
   bank_s st_nxt;

   logic div_start;
   logic [31:0] div_dividend;
   logic [31:0] div_divisor;
   logic div_busy;
   logic div_done;
   logic [31:0] div_quotient;

   // ==========================================================
   // Gain divider
   seq_divider #(
      .W(32)
   ) u_div (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_start(div_start),
      .i_dividend(div_dividend),
      .i_divisor(div_divisor),
      .o_busy(div_busy),
      .o_done(div_done),
      .o_quotient(div_quotient)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic signed [16:0] net;
      logic take;
      logic [31:0] rd;
      logic [2:0] sts;
      logic rd_ok;
      logic wr_ok;
      net = 17'(i_raw_reading) - 17'($signed(st_r.offset));
      take = 1'b0;
      rd = '0;
      sts = param_bank_pkg::ST_OK;
      rd_ok = 1'b0;
      wr_ok = 1'b0;
      div_start = 1'b0;
      div_dividend = i_req_wdata;
      div_divisor = 32'(net[15:0]);
      st_nxt = st_r;
      st_nxt.rsp_valid = 1'b0;

      st_nxt.link_s1 = i_link_ok;
      st_nxt.link_s2 = st_r.link_s1;
      st_nxt.ovl_s1 = i_overload;
      st_nxt.ovl_s2 = st_r.ovl_s1;

      // Connection supervision
      case (st_r.conn)
         param_bank_pkg::CONN_IDLE: begin
            if (i_boot_done && st_r.link_s2) begin
               st_nxt.conn = param_bank_pkg::CONN_UP;
               st_nxt.connected = 1'b1;
            end
         end
         param_bank_pkg::CONN_UP: begin
            if (st_r.ovl_s2 || !st_r.link_s2) begin
               st_nxt.conn = param_bank_pkg::CONN_LOST;
               st_nxt.connected = 1'b0;
               st_nxt.wait_cnt = '0;
            end
         end
         param_bank_pkg::CONN_LOST: begin
            if (st_r.ovl_s2 || !st_r.link_s2) begin
               st_nxt.wait_cnt = '0;
            end else if (st_r.wait_cnt >= 32'(RECONNECT_CYCLES - 1)) begin
               st_nxt.conn = param_bank_pkg::CONN_UP;
               st_nxt.connected = 1'b1;
            end else begin
               st_nxt.wait_cnt = st_r.wait_cnt + 32'h00000001;
            end
         end
         default: begin
            st_nxt.conn = param_bank_pkg::CONN_IDLE;
            st_nxt.connected = 1'b0;
         end
      endcase

      // Request handling
      case (st_r.phase)
         param_bank_pkg::PH_IDLE: begin
            take = i_req_valid;
            case (i_req_index)
               param_bank_pkg::IDX_DEVICE_TYPE_ID: begin
                  rd_ok = 1'b1;
                  rd = 32'(DEVICE_TYPE);
               end
               param_bank_pkg::IDX_FIRMWARE_VERSION: begin
                  rd_ok = 1'b1;
                  rd = 32'(FW_VERSION);
               end
               param_bank_pkg::IDX_NETWORK_FILTER_ENABLE: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = 32'(st_r.net_flt_en);
               end
               param_bank_pkg::IDX_ANALOG_FILTER_ENABLE: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = 32'(st_r.ana_flt_en);
               end
               param_bank_pkg::IDX_ZERO_OFFSET: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = 32'($signed(st_r.offset));
               end
               param_bank_pkg::IDX_SCALE_GAIN: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = 32'(st_r.gain);
               end
               param_bank_pkg::IDX_FULL_SCALE_FORCE: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = st_r.force_fs;
               end
               param_bank_pkg::IDX_ANALOG_OUTPUT_SCALING: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = st_r.scaling;
               end
               param_bank_pkg::IDX_NETWORK_FILTER_CUTOFF: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = 32'(st_r.net_cut);
               end
               param_bank_pkg::IDX_ANALOG_FILTER_CUTOFF: begin
                  {rd_ok, wr_ok} = 2'h3;
                  rd = 32'(st_r.ana_cut);
               end
               param_bank_pkg::IDX_OFFSET_COMP_CMD: begin
                  wr_ok = 1'b1;
               end
               param_bank_pkg::IDX_CALIBRATION_WEIGHT_CMD: begin
                  wr_ok = 1'b1;
               end
               default: begin
                  sts = param_bank_pkg::ST_BAD_INDEX;
               end
            endcase
            if (!i_boot_done || !st_r.connected) begin
               sts = param_bank_pkg::ST_NOT_READY;
            end else if (i_req_slot != PARAM_SLOT) begin
               sts = param_bank_pkg::ST_BAD_SLOT;
            end else if (sts == param_bank_pkg::ST_OK &&
                         (i_req_write ? !wr_ok : !rd_ok)) begin
               sts = param_bank_pkg::ST_BAD_ACCESS;
            end else if (sts == param_bank_pkg::ST_OK && i_req_write) begin
               case (i_req_index)
                  param_bank_pkg::IDX_NETWORK_FILTER_ENABLE,
                  param_bank_pkg::IDX_ANALOG_FILTER_ENABLE: begin
                     if (i_req_wdata > 32'h00000001) begin
                        sts = param_bank_pkg::ST_BAD_RANGE;
                     end
                  end
                  param_bank_pkg::IDX_ZERO_OFFSET: begin
                     if ($signed(i_req_wdata) <
                         32'($signed(param_bank_pkg::OFFSET_MIN)) ||
                         $signed(i_req_wdata) >
                         32'($signed(param_bank_pkg::OFFSET_MAX))) begin
                        sts = param_bank_pkg::ST_BAD_RANGE;
                     end
                  end
                  param_bank_pkg::IDX_SCALE_GAIN: begin
                     if (i_req_wdata > 32'(param_bank_pkg::GAIN_MAX)) begin
                        sts = param_bank_pkg::ST_BAD_RANGE;
                     end
                  end
                  param_bank_pkg::IDX_FULL_SCALE_FORCE,
                  param_bank_pkg::IDX_ANALOG_OUTPUT_SCALING: begin
                     if (i_req_wdata > param_bank_pkg::FORCE_MAX) begin
                        sts = param_bank_pkg::ST_BAD_RANGE;
                     end
                  end
                  param_bank_pkg::IDX_NETWORK_FILTER_CUTOFF,
                  param_bank_pkg::IDX_ANALOG_FILTER_CUTOFF: begin
                     if (i_req_wdata < 32'(param_bank_pkg::CUTOFF_MIN) ||
                         i_req_wdata > 32'(param_bank_pkg::CUTOFF_MAX)) begin
                        sts = param_bank_pkg::ST_BAD_RANGE;
                     end
                  end
                  param_bank_pkg::IDX_OFFSET_COMP_CMD: begin
                     if (i_raw_reading < param_bank_pkg::OFFSET_MIN ||
                         i_raw_reading > param_bank_pkg::OFFSET_MAX) begin
                        sts = param_bank_pkg::ST_BAD_RANGE;
                     end
                  end
                  param_bank_pkg::IDX_CALIBRATION_WEIGHT_CMD: begin
                     if ($signed(i_req_wdata) <= 32'sh00000000 ||
                         $signed(i_req_wdata) >
                         param_bank_pkg::WEIGHT_MAX ||
                         net <= 17'sh00000) begin
                        sts = param_bank_pkg::ST_CAL_FAIL;
                     end
                  end
                  default: begin
                     sts = param_bank_pkg::ST_BAD_INDEX;
                  end
               endcase
            end
            if (take) begin
               st_nxt.rsp_valid = 1'b1;
               st_nxt.rsp_status = sts;
               st_nxt.rsp_rdata = (sts == param_bank_pkg::ST_OK &&
                                   !i_req_write) ? rd : 32'h00000000;
               if (sts == param_bank_pkg::ST_OK && i_req_write) begin
                  case (i_req_index)
                     param_bank_pkg::IDX_NETWORK_FILTER_ENABLE: begin
                        st_nxt.net_flt_en = i_req_wdata[0];
                     end
                     param_bank_pkg::IDX_ANALOG_FILTER_ENABLE: begin
                        st_nxt.ana_flt_en = i_req_wdata[0];
                     end
                     param_bank_pkg::IDX_ZERO_OFFSET: begin
                        st_nxt.offset = i_req_wdata[15:0];
                     end
                     param_bank_pkg::IDX_SCALE_GAIN: begin
                        st_nxt.gain = i_req_wdata[15:0];
                     end
                     param_bank_pkg::IDX_FULL_SCALE_FORCE: begin
                        st_nxt.force_fs = i_req_wdata;
                     end
                     param_bank_pkg::IDX_ANALOG_OUTPUT_SCALING: begin
                        st_nxt.scaling = i_req_wdata;
                     end
                     param_bank_pkg::IDX_NETWORK_FILTER_CUTOFF: begin
                        st_nxt.net_cut = i_req_wdata[15:0];
                     end
                     param_bank_pkg::IDX_ANALOG_FILTER_CUTOFF: begin
                        st_nxt.ana_cut = i_req_wdata[15:0];
                     end
                     param_bank_pkg::IDX_OFFSET_COMP_CMD: begin
                        st_nxt.offset = i_raw_reading;
                     end
                     param_bank_pkg::IDX_CALIBRATION_WEIGHT_CMD: begin
                        st_nxt.rsp_valid = 1'b0;
                        st_nxt.phase = param_bank_pkg::PH_CALC;
                        st_nxt.busy = 1'b1;
                        div_start = 1'b1;
                     end
                     default: begin
                        st_nxt.rsp_status = param_bank_pkg::ST_BAD_INDEX;
                     end
                  endcase
               end
            end
         end
         param_bank_pkg::PH_CALC: begin
            if (div_done) begin
               st_nxt.phase = param_bank_pkg::PH_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.rsp_valid = 1'b1;
               st_nxt.rsp_rdata = 32'h00000000;
               if (div_quotient > 32'(param_bank_pkg::GAIN_MAX)) begin
                  st_nxt.rsp_status = param_bank_pkg::ST_CAL_FAIL;
               end else begin
                  st_nxt.rsp_status = param_bank_pkg::ST_OK;
                  st_nxt.gain = div_quotient[15:0];
               end
            end
         end
         default: begin
            st_nxt.phase = param_bank_pkg::PH_IDLE;
            st_nxt.busy = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
         st_r.conn <= param_bank_pkg::CONN_IDLE;
         st_r.phase <= param_bank_pkg::PH_IDLE;
         st_r.net_flt_en <= param_bank_pkg::RST_FILTER_ENABLE;
         st_r.ana_flt_en <= param_bank_pkg::RST_FILTER_ENABLE;
         st_r.offset <= param_bank_pkg::RST_ZERO_OFFSET;
         st_r.gain <= param_bank_pkg::RST_SCALE_GAIN;
         st_r.force_fs <= param_bank_pkg::RST_FULL_SCALE_FORCE;
         st_r.scaling <= param_bank_pkg::RST_ANALOG_OUTPUT_SCALING;
         st_r.net_cut <= param_bank_pkg::RST_FILTER_CUTOFF;
         st_r.ana_cut <= param_bank_pkg::RST_FILTER_CUTOFF;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign o_busy = st_r.busy;
   assign o_rsp_valid = st_r.rsp_valid;
   assign o_rsp_status = st_r.rsp_status;
   assign o_rsp_rdata = st_r.rsp_rdata;
   assign o_connected = st_r.connected;
   assign o_network_filter_enable = st_r.net_flt_en;
   assign o_analog_filter_enable = st_r.ana_flt_en;
   assign o_zero_offset = st_r.offset;
   assign o_scale_gain = st_r.gain;
   assign o_full_scale_force = st_r.force_fs;
   assign o_analog_output_scaling = st_r.scaling;
   assign o_network_filter_cutoff = st_r.net_cut;
   assign o_analog_filter_cutoff = st_r.ana_cut;
endmodule : acyclic_parameter_access

/* File: hw/param_bank_pkg.sv */
// Constants, types and index map of the acyclic parameter bank.
// Assumes a single 25 MHz clock domain shared by all users of the package.
//
// Functional notes
// - No parameter request is served until the device reports that boot has completed.
// - Every read or write request arriving while no calibration is running is answered with a status and, for reads with OK status, the data.
// - A write to the offset compensation index takes the present raw reading as the new offset if it lies within the offset range.
// - After an overload drops the connection, the device reconnects by itself after the hold-off time.
// - Records travel as request and answer frames over UDP on IP.
package param_bank_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned RECONNECT_MS = 3000;
   localparam int unsigned RECONNECT_CYCLES = RECONNECT_MS * (CLK_HZ / 1000);

   // ==========================================================
   // Parameter and instruction indices
   localparam logic [7:0] IDX_DEVICE_TYPE_ID = 8'h01;
   localparam logic [7:0] IDX_FIRMWARE_VERSION = 8'h02;
   localparam logic [7:0] IDX_NETWORK_FILTER_ENABLE = 8'h10;
   localparam logic [7:0] IDX_ANALOG_FILTER_ENABLE = 8'h11;
   localparam logic [7:0] IDX_ZERO_OFFSET = 8'h20;
   localparam logic [7:0] IDX_SCALE_GAIN = 8'h21;
   localparam logic [7:0] IDX_FULL_SCALE_FORCE = 8'h22;
   localparam logic [7:0] IDX_ANALOG_OUTPUT_SCALING = 8'h23;
   localparam logic [7:0] IDX_NETWORK_FILTER_CUTOFF = 8'h24;
   localparam logic [7:0] IDX_ANALOG_FILTER_CUTOFF = 8'h25;
   localparam logic [7:0] IDX_OFFSET_COMP_CMD = 8'h30;
   localparam logic [7:0] IDX_CALIBRATION_WEIGHT_CMD = 8'h31;

   // ==========================================================
   // Values after reset
   localparam logic RST_FILTER_ENABLE = 1'b0;
   localparam logic [15:0] RST_ZERO_OFFSET = 16'h0000;
   localparam logic [15:0] RST_SCALE_GAIN = 16'h03E8;
   localparam logic [31:0] RST_FULL_SCALE_FORCE = 32'h000F4240;
   localparam logic [31:0] RST_ANALOG_OUTPUT_SCALING = 32'h000F4240;
   localparam logic [15:0] RST_FILTER_CUTOFF = 16'h0064;

   // ==========================================================
   // Value ranges
   localparam logic signed [15:0] OFFSET_MIN = -16'sd8000;
   localparam logic signed [15:0] OFFSET_MAX = 16'sd8000;
   localparam logic [15:0] GAIN_MAX = 16'h4E20;
   localparam logic [31:0] FORCE_MAX = 32'h0BEBC200;
   localparam logic [15:0] CUTOFF_MIN = 16'h0001;
   localparam logic [15:0] CUTOFF_MAX = 16'h07D0;
   localparam logic signed [31:0] WEIGHT_MAX = 32'sh0BEBC200;

   // ==========================================================
   // Answer status codes
   localparam logic [2:0] ST_OK = 3'h0;
   localparam logic [2:0] ST_BAD_INDEX = 3'h1;
   localparam logic [2:0] ST_BAD_ACCESS = 3'h2;
   localparam logic [2:0] ST_BAD_RANGE = 3'h3;
   localparam logic [2:0] ST_NOT_READY = 3'h4;
   localparam logic [2:0] ST_BAD_SLOT = 3'h5;
   localparam logic [2:0] ST_CAL_FAIL = 3'h6;

   // ==========================================================
   // States
   typedef enum logic [0:0] {PH_IDLE, PH_CALC} phase_e;
   typedef enum logic [1:0] {CONN_IDLE, CONN_UP, CONN_LOST} conn_e;
endpackage : param_bank_pkg

/* File: hw/seq_divider.sv */
// Unsigned restoring divider, one quotient bit per clock.
// Assumes the caller holds off a new start while busy is high.
module seq_divider #(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Operands
   input wire logic i_start,
   input wire logic [W-1:0] i_dividend,
   input wire logic [W-1:0] i_divisor,
   // Result
   output logic o_busy,
   output logic o_done,
   output logic [W-1:0] o_quotient
);
   localparam int CW = $clog2(W) + 1;

   typedef struct packed {
      logic busy;
      logic done;
      logic [CW-1:0] cnt;
      logic [W:0] rem;
      logic [W-1:0] quo;
      logic [W-1:0] dvs;
   } div_s;

   div_s st_r;
   div_s st_nxt;

   // ==========================================================
   // Next state
   always_comb begin
      logic [W:0] trial;
      trial = '0;
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (i_start && !st_r.busy) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt = CW'(W);
         st_nxt.rem = '0;
         st_nxt.quo = i_dividend;
         st_nxt.dvs = i_divisor;
      end else if (st_r.busy) begin
         trial = {st_r.rem[W-1:0], st_r.quo[W-1]};
         st_nxt.quo = {st_r.quo[W-2:0], 1'b0};
         if (trial >= {1'b0, st_r.dvs}) begin
            st_nxt.rem = trial - {1'b0, st_r.dvs};
            st_nxt.quo[0] = 1'b1;
         end else begin
            st_nxt.rem = trial;
         end
         st_nxt.cnt = st_r.cnt - CW'(1);
         if (st_r.cnt == CW'(1)) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_busy = st_r.busy;
   assign o_done = st_r.done;
   assign o_quotient = st_r.quo;
endmodule : seq_divider

/* File: tb/acyclic_parameter_access_tb.sv */
// Self-checking bench driving the parameter bank through the model.
// Assumes the design package and both tb modules are compiled first.
module acyclic_parameter_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned RC = 20;
   logic i_clk = 1'b0, i_nrst = 1'b1, boot = 1'b0, link = 1'b1, ovl = 1'b0;
   logic signed [15:0] raw = 16'sh0064;
   logic rd = 1'b0, wr = 1'b0, bad = 1'b0, got, rv, rw, busy, rsp, conn;
   logic [7:0] idx = 8'h00, ri;
   logic [15:0] rs, gain;
   logic [31:0] val = 32'h0, wd, rdat, vr;
   logic [2:0] st, rst;
   int num_errors = 0, total_checks = 0;
   logic [7:0] ix [8] = '{8'h10, 8'h11, 8'h20, 8'h21, 8'h22, 8'h23,
      8'h24, 8'h25};
   logic [31:0] iv [8] = '{32'h0, 32'h0, 32'h0, 32'h3E8, 32'hF4240,
      32'hF4240, 32'h64, 32'h64};
   logic [31:0] wv [8] = '{32'h1, 32'h1, 32'hFFFFE0C0, 32'h4E20,
      32'h0BEBC200, 32'h0BEBC200, 32'h7D0, 32'h1};
   logic ew [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   logic [7:0] ei [7] = '{8'h01, 8'h30, 8'h31, 8'h40, 8'h10, 8'h24, 8'h21};
   logic [31:0] ed [7] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h2, 32'h0, 32'h4E21};
   logic [2:0] es [7] = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h3, 3'h3};
   acyclic_parameter_access #(.RECONNECT_CYCLES(RC))
   acyclic_parameter_access_i (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_boot_done(boot), .i_link_ok(link), .i_overload(ovl),
      .i_raw_reading(raw), .i_req_valid(rv), .i_req_write(rw),
      .i_req_slot(rs), .i_req_index(ri), .i_req_wdata(wd), .o_busy(busy),
      .o_rsp_valid(rsp), .o_rsp_status(rst), .o_rsp_rdata(rdat),
      .o_connected(conn), .o_network_filter_enable(),
      .o_analog_filter_enable(), .o_zero_offset(), .o_scale_gain(gain),
      .o_full_scale_force(), .o_analog_output_scaling(),
      .o_network_filter_cutoff(), .o_analog_filter_cutoff());
   plc_model plc_model_i (.i_clk(i_clk), .i_rd_trig(rd), .i_wr_trig(wr),
      .i_wrong_slot(bad), .i_index(idx), .i_value(val), .i_rsp_valid(rsp),
      .i_rsp_status(rst), .i_rsp_rdata(rdat), .o_req_valid(rv),
      .o_req_write(rw), .o_got(got), .o_req_slot(rs), .o_req_index(ri),
      .o_req_wdata(wd), .o_value_read(vr), .o_status(st));
   always #20 i_clk = ~i_clk;
   // ==========================================
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %h, not %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic w, input logic [7:0] i,
      input logic [31:0] d, input logic [2:0] s, input logic [31:0] r);
      @(negedge i_clk);
      {rd, wr, idx, val} <= {!w, w, i, d};
      @(negedge i_clk);
      {rd, wr} <= 2'b00;
      repeat (2) @(negedge i_clk);
      for (int k = 0; k < 45 && got !== 1'b1; k++) @(negedge i_clk);
      check({28'h0, got, st}, {28'h0, 1'b1, s});
      check(vr, r);
   endtask : acc
   task automatic wait_conn;
      for (int k = 0; k < 2 * RC + 10 && conn !== 1'b1; k++) @(negedge i_clk);
      check({31'h0, conn}, 32'h1);
   endtask : wait_conn
   task automatic results;
      $display("Checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   // ==========================================
   // Tests
   initial begin : watchdog
      #400000;
      num_errors++;
      results();
   end
   initial begin : main
      i_nrst <= 1'b0;
      repeat (10) @(negedge i_clk);
      i_nrst <= 1'b1;
      acc(1'b0, 8'h21, 32'h0, 3'h4, 32'h0);
      boot <= 1'b1;
      wait_conn();
      acc(1'b0, 8'h01, 32'h0, 3'h0, 32'h0A5A);
      acc(1'b0, 8'h02, 32'h0, 3'h0, 32'h0064);
      foreach (ix[k]) acc(1'b0, ix[k], 32'h0, 3'h0, iv[k]);
      foreach (ix[k]) begin
         acc(1'b1, ix[k], wv[k], 3'h0, 32'h0);
         acc(1'b0, ix[k], 32'h0, 3'h0, wv[k]);
      end
      foreach (ei[k]) acc(ew[k], ei[k], ed[k], es[k], 32'h0);
      bad <= 1'b1;
      acc(1'b0, 8'h21, 32'h0, 3'h5, 32'h0);
      bad <= 1'b0;
      $display("Test access codes done");
      acc(1'b1, 8'h30, 32'h0, 3'h0, 32'h0);
      acc(1'b0, 8'h20, 32'h0, 3'h0, 32'h64);
      raw <= 16'sh0164;
      acc(1'b1, 8'h31, 32'h0007D000, 3'h0, 32'h0);
      acc(1'b0, 8'h21, 32'h0, 3'h0, 32'h7D0);
      check({16'h0, gain}, 32'h7D0);
      $display("Test instructions done");
      ovl <= 1'b1;
      repeat (5) @(negedge i_clk);
      acc(1'b0, 8'h21, 32'h0, 3'h4, 32'h0);
      ovl <= 1'b0;
      wait_conn();
      $display("Test reconnect done");
      i_nrst <= 1'b0;
      repeat (2) @(negedge i_clk);
      i_nrst <= 1'b1;
      wait_conn();
      acc(1'b0, 8'h10, 32'h0, 3'h0, 32'h0);
      acc(1'b0, 8'h11, 32'h0, 3'h0, 32'h0);
      $display("Test restart done");
      results();
   end
endmodule : acyclic_parameter_access_tb

/* File: tb/param_bank_asserts.sv */
// Checker on the answer and parameter ports of the parameter bank.
// Assumes it is bound into acyclic_parameter_access, one clock domain.
module param_bank_asserts #(
   parameter logic [15:0] PARAM_SLOT = 16'h0001
) (
   input wire logic i_clk, i_nrst, i_req_valid, i_req_write,
   input wire logic [15:0] i_req_slot,
   input wire logic [7:0] i_req_index,
   input wire logic signed [15:0] i_raw_reading,
   input wire logic o_busy, o_rsp_valid, o_connected,
   input wire logic [2:0] o_rsp_status,
   input wire logic [15:0] o_zero_offset,
   input wire logic o_network_filter_enable, o_analog_filter_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   logic take, good;
   assign take = i_req_valid && !o_busy;
   assign good = take && o_connected && i_req_slot == PARAM_SLOT;
   // ==========================================
   // Answers
   AST_NOT_READY: assert property (
      take && !o_connected |=> o_rsp_valid && o_rsp_status == 3'h4)
      else $error("No not-ready answer");
   AST_ANSWER: assert property (
      take && !(i_req_write && i_req_index == 8'h31) |=> o_rsp_valid)
      else $error("Request not answered");
   AST_RO_WRITE: assert property (
      good && i_req_write && i_req_index inside {8'h01, 8'h02}
      |=> o_rsp_status == 3'h2) else $error("Read-only write taken");
   AST_WO_READ: assert property (
      good && !i_req_write && i_req_index inside {8'h30, 8'h31}
      |=> o_rsp_status == 3'h2) else $error("Write-only read taken");
   AST_BAD_SLOT: assert property (
      take && o_connected && i_req_slot != PARAM_SLOT
      |=> o_rsp_status == 3'h5) else $error("Wrong slot taken");
   AST_OFFSET_COMP: assert property (
      good && i_req_write && i_req_index == 8'h30 &&
      i_raw_reading >= param_bank_pkg::OFFSET_MIN &&
      i_raw_reading <= param_bank_pkg::OFFSET_MAX
      |=> o_zero_offset == $past(i_raw_reading))
      else $error("Offset not taken from reading");
   AST_CAL_TIME: assert property (
      $rose(o_busy) |-> o_busy [*8] ##26 !o_busy && o_rsp_valid)
      else $error("Calibration answer time wrong");
   AST_HOLD_OFF: assert property (
      $fell(o_connected) |-> !o_connected [*8])
      else $error("Reconnect too early");
   AST_FILT_RST: assert property (disable iff (1'b0)
      !i_nrst |-> !o_network_filter_enable && !o_analog_filter_enable)
      else $error("Filter enable set in reset");
endmodule : param_bank_asserts

bind acyclic_parameter_access param_bank_asserts #(
   .PARAM_SLOT(PARAM_SLOT)
) param_bank_asserts_i (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_req_valid(i_req_valid), .i_req_write(i_req_write),
   .i_req_slot(i_req_slot), .i_req_index(i_req_index),
   .i_raw_reading(i_raw_reading), .o_busy(o_busy),
   .o_rsp_valid(o_rsp_valid), .o_connected(o_connected),
   .o_rsp_status(o_rsp_status), .o_zero_offset(o_zero_offset),
   .o_network_filter_enable(o_network_filter_enable),
   .o_analog_filter_enable(o_analog_filter_enable));

/* File: tb/plc_model.sv */
// Controller model: turns one-shot triggers into decoded records.
// Assumes the bench moves the triggers on the falling clock edge.
module plc_model #(
   parameter logic [15:0] SLOT = 16'h0001
) (
   input wire logic i_clk, i_rd_trig, i_wr_trig, i_wrong_slot,
   input wire logic [7:0] i_index,
   input wire logic [31:0] i_value,
   input wire logic i_rsp_valid,
   input wire logic [2:0] i_rsp_status,
   input wire logic [31:0] i_rsp_rdata,
   output logic o_req_valid, o_req_write, o_got,
   output logic [15:0] o_req_slot,
   output logic [7:0] o_req_index,
   output logic [31:0] o_req_wdata, o_value_read,
   output logic [2:0] o_status
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {o_req_valid, o_req_write, o_got, o_status} = '0;
      {o_req_slot, o_req_index, o_req_wdata, o_value_read} = '0;
   end
   // Record sent only when flagged; qualifiers scramble otherwise
   always @(negedge i_clk) begin
      o_req_valid <= i_rd_trig || i_wr_trig;
      o_req_write <= i_wr_trig;
      if (i_rd_trig || i_wr_trig) begin
         o_req_slot <= i_wrong_slot ? ~SLOT : SLOT;
         o_req_index <= i_index;
         o_req_wdata <= i_value;
      end else begin
         o_req_slot <= ~o_req_slot;
         o_req_index <= ~o_req_index;
         o_req_wdata <= ~o_req_wdata;
      end
   end
   always @(posedge i_clk) begin
      if (o_req_valid) o_got <= 1'b0;
      if (i_rsp_valid) begin
         o_got <= 1'b1;
         o_status <= i_rsp_status;
         o_value_read <= i_rsp_rdata;
      end
   end
endmodule : plc_model
